// ===== logic/lnk_ilas_cmp.sv
// Byte-wise comparison of received and programmed alignment configuration
`timescale 1ns/10ps
`default_nettype none
`include "lnk_regs.svh"
module lnk_ilas_cmp
	import lnk_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic start,
	input wire lnk_cfg_t rx_cfg,
	input wire lnk_cfg_t prog_cfg,
	output logic mismatch
);
	logic [`LNK_CFG_BYTES-1:0] byte_diff; // Per-byte inequality
	logic next_mismatch; // Registered pulse next value

	////////////////////////////////////////////////////////////////////////////
	// Every byte compared, checksum byte included
	genvar gi;
	generate
		for (gi = 0; gi < `LNK_CFG_BYTES; gi++) begin : g_byte
			assign byte_diff[gi] = rx_cfg[gi*8 +: 8] != prog_cfg[gi*8 +: 8];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Pulse only in the cycle after a start strobe
	always_comb begin
		next_mismatch = start & (|byte_diff);
	end

	// Register the result so the pulse is glitch-free
	always_ff @(posedge clk) begin
		if (!resetn) begin
			mismatch <= 1'b0;
		end else if (ce) begin
			mismatch <= next_mismatch;
		end
	end
endmodule // lnk_ilas_cmp
`default_nettype wire

// ===== logic/lnk_irq_top.sv
// Link receive interrupt enable and status registers with interrupt request
`timescale 1ns/10ps
`default_nettype none
`include "lnk_regs.svh"
module lnk_irq_top
	import lnk_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire lnk_addr_t reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire lnk_byte_t reg_wdata,
	output lnk_byte_t reg_rdata,
	input wire logic disparity_err_evt,
	input wire logic not_in_table_evt,
	input wire logic unexp_ctrl_evt,
	input wire logic lane_deskew_evt,
	input wire logic init_lane_sync_evt,
	input wire logic frame_sync_evt,
	input wire logic code_group_sync_evt,
	input wire logic ilas_done,
	input wire lnk_byte_t rx_checksum,
	input wire lnk_byte_t calc_checksum,
	input wire logic lane0_ilas_done,
	input wire lnk_cfg_t lane0_rx_cfg,
	input wire lnk_cfg_t prog_cfg,
	output logic link_irq
);
	lnk_byte_t enable_a; // Enables, status A sources
	logic enable_b0; // Config mismatch enable
	lnk_byte_t status_a; // Sticky source flags
	logic status_b0; // Sticky config mismatch flag
	lnk_byte_t next_enable_a; // Enable A after this edge
	logic next_enable_b0; // Enable B bit 0 after this edge
	lnk_byte_t next_status_a; // Status A after set and clear
	logic next_status_b0; // Status B bit 0 after set and clear
	lnk_byte_t next_rdata; // Read data to register
	logic next_irq; // Request to register
	lnk_byte_t src_evt; // Event vector in status A order
	logic cks_evt; // Checksum mismatch event
	logic cfg_evt; // Config mismatch event, from comparator
	logic wr_en_a; // Write to enable A this cycle
	logic wr_en_b; // Write to enable B this cycle
	logic wr_st_a; // Write-one clear to status A
	logic wr_st_b; // Write-one clear to status B

	////////////////////////////////////////////////////////////////////////////
	// Source events

	// Link-sent checksum against receiver-computed one; the programmed
	// checksum reaches this block only inside prog_cfg, for the config compare
	assign cks_evt = ilas_done & (rx_checksum != calc_checksum);

	// Lane 0 configuration compare, one cycle of latency
	lnk_ilas_cmp u_cmp (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.start(lane0_ilas_done),
		.rx_cfg(lane0_rx_cfg),
		.prog_cfg(prog_cfg),
		.mismatch(cfg_evt)
	);

	// Gather events into the shared bit layout
	always_comb begin
		src_evt = 8'h00;
		src_evt[`LNK_BIT_DISPARITY] = disparity_err_evt;
		src_evt[`LNK_BIT_NOT_IN_TABLE] = not_in_table_evt;
		src_evt[`LNK_BIT_UNEXP_CTRL] = unexp_ctrl_evt;
		src_evt[`LNK_BIT_LANE_DESKEW] = lane_deskew_evt;
		src_evt[`LNK_BIT_INIT_LANE_SYNC] = init_lane_sync_evt;
		src_evt[`LNK_BIT_CHECKSUM] = cks_evt;
		src_evt[`LNK_BIT_FRAME_SYNC] = frame_sync_evt;
		src_evt[`LNK_BIT_CODE_GROUP_SYNC] = code_group_sync_evt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Register decode
	assign wr_en_a = reg_wr && (reg_addr == `LNK_OFS_ENABLE_A);
	assign wr_en_b = reg_wr && (reg_addr == `LNK_OFS_ENABLE_B);
	assign wr_st_a = reg_wr && (reg_addr == `LNK_OFS_STATUS_A);
	assign wr_st_b = reg_wr && (reg_addr == `LNK_OFS_STATUS_B);

	////////////////////////////////////////////////////////////////////////////
	// Next-state: enables, sticky flags, read data, request
	always_comb begin
		// Enables are plain storage
		next_enable_a = wr_en_a ? reg_wdata : enable_a;
		// Bits 7:1 of B have no storage at all
		next_enable_b0 = wr_en_b ? reg_wdata[`LNK_BIT_CONFIG_MISMATCH] : enable_b0;
		// Writing one clears; a same-cycle event still sets, so none is lost
		next_status_a = (status_a & ~(wr_st_a ? reg_wdata : 8'h00)) | src_evt;
		next_status_b0 = (status_b0 & ~(wr_st_b & reg_wdata[`LNK_BIT_CONFIG_MISMATCH]))
			| cfg_evt;
		// Read mux; unmapped addresses read zero
		next_rdata = reg_rdata;
		if (reg_rd) begin
			case (reg_addr)
				`LNK_OFS_ENABLE_A: next_rdata = enable_a;
				`LNK_OFS_ENABLE_B: next_rdata = {7'h00, enable_b0};
				`LNK_OFS_STATUS_A: next_rdata = status_a;
				`LNK_OFS_STATUS_B: next_rdata = {7'h00, status_b0};
				default: next_rdata = 8'h00;
			endcase
		end
		// Request tracks current flags, one register stage behind
		next_irq = (|(status_a & enable_a)) | (status_b0 & enable_b0);
	end

	// State registers, frozen while ce is low
	always_ff @(posedge clk) begin
		if (!resetn) begin
			enable_a <= `LNK_RST_ENABLE_A;
			enable_b0 <= 1'b0;
			status_a <= `LNK_RST_STATUS_A;
			status_b0 <= 1'b0;
			reg_rdata <= 8'h00;
			link_irq <= 1'b0;
		end else if (ce) begin
			enable_a <= next_enable_a;
			enable_b0 <= next_enable_b0;
			status_a <= next_status_a;
			status_b0 <= next_status_b0;
			reg_rdata <= next_rdata;
			link_irq <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_cfg_diff;
		ce && lane0_ilas_done && (lane0_rx_cfg != prog_cfg);
	endsequence
	sequence s_flag_up;
		ce [*2] ##0 status_b0;
	endsequence

	// Enable A stores the written byte as is
	a_enable_a_write: assert property (ce && wr_en_a |=> enable_a == $past(reg_wdata))
		else $error("enable A write not stored");
	// Every source pulse lands in its status bit
	a_status_a_set: assert property (ce && |src_evt
		|=> (status_a & $past(src_evt)) == $past(src_evt))
		else $error("status A event lost");
	a_status_a_clear: assert property (ce && wr_st_a && reg_wdata[0] && !src_evt[0]
		|=> !status_a[0])
		else $error("status A write one did not clear");
	// Checksum flag follows the link-side compare only
	a_cks_mismatch: assert property (ce && ilas_done && rx_checksum != calc_checksum
		|=> status_a[`LNK_BIT_CHECKSUM])
		else $error("checksum mismatch not flagged");
	a_cks_match_quiet: assert property (ce && !status_a[`LNK_BIT_CHECKSUM] && !wr_st_a
		&& !(ilas_done && rx_checksum != calc_checksum) |=> !status_a[`LNK_BIT_CHECKSUM])
		else $error("checksum flag set without link mismatch");
	// Lane 0 image compare reaches status B two edges after the strobe
	a_cfg_mismatch: assert property (s_cfg_diff ##1 ce |=> status_b0)
		else $error("config mismatch not flagged within two cycles");
	a_cfg_flag_hold: assert property (s_flag_up ##0 !(wr_st_b && reg_wdata[0])
		|=> status_b0)
		else $error("config mismatch flag dropped without clear");
	// Reserved upper bits of the B registers always read zero
	a_reserved_zero: assert property ($past(reg_rd) && $past(ce)
		&& ($past(reg_addr) == `LNK_OFS_ENABLE_B || $past(reg_addr) == `LNK_OFS_STATUS_B)
		|-> reg_rdata[7:1] == 7'h00)
		else $error("reserved bits read nonzero");
	// Request is the registered OR of enabled flags
	a_irq_follow: assert property (ce |=> link_irq
		== (|($past(status_a) & $past(enable_a)) || ($past(status_b0) && $past(enable_b0))))
		else $error("interrupt request wrong");

	////////////////////////////////////////////////////////////////////////////
	// Further checks on the B registers, the comparator, the request, clock enable freeze and read data hold

	// An enabled source pulse with no enable write in its way
	sequence s_enabled_evt;
		ce && |(src_evt & enable_a) && !wr_en_a;
	endsequence
	// A cycle that neither writes enable A nor clears status A
	sequence s_quiet_a;
		ce && !wr_en_a && !wr_st_a;
	endsequence
	// Status B write-one clear with no compare pulse arriving
	sequence s_clear_b;
		ce && wr_st_b && reg_wdata[`LNK_BIT_CONFIG_MISMATCH] && !cfg_evt;
	endsequence

	// Enabled event reaches the request two edges after the pulse
	a_evt_to_irq: assert property (s_enabled_evt ##1 s_quiet_a |=> link_irq)
		else $error("enabled event did not raise the request");
	// Enable B keeps bit 0 only
	a_enable_b_set: assert property (ce && wr_en_b && reg_wdata[`LNK_BIT_CONFIG_MISMATCH]
		|=> enable_b0)
		else $error("enable B set not stored");
	a_enable_b_clr: assert property (ce && wr_en_b && !reg_wdata[`LNK_BIT_CONFIG_MISMATCH]
		|=> !enable_b0)
		else $error("enable B clear not stored");
	// Write one clears the mismatch flag when no pulse competes
	a_status_b_clear: assert property (s_clear_b |=> !status_b0)
		else $error("status B write one did not clear");
	// Compare pulse wins over a same-cycle clear
	a_status_b_set_wins: assert property (ce && cfg_evt |=> status_b0)
		else $error("config mismatch pulse lost");
	// Comparator pulses only after a lane 0 strobe, never on a match
	a_cfg_pulse_gate: assert property (ce && !lane0_ilas_done |=> !cfg_evt)
		else $error("compare pulse without strobe");
	a_cfg_match_quiet: assert property (ce && lane0_ilas_done && lane0_rx_cfg == prog_cfg
		|=> !cfg_evt)
		else $error("compare pulse on equal images");
	// Low clock enable freezes every register
	a_ce_freeze: assert property (!ce |=> $stable(enable_a) && $stable(enable_b0)
		&& $stable(status_a) && $stable(status_b0) && $stable(reg_rdata) && $stable(link_irq))
		else $error("state moved while clock enable low");
	// Read data stands until the next read
	a_rdata_hold: assert property (ce && !reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");
	// No enable, no request
	a_irq_masked: assert property (ce && enable_a == 8'h00 && !enable_b0 |=> !link_irq)
		else $error("request raised with all sources masked");
endmodule // lnk_irq_top
`default_nettype wire

// ===== logic/lnk_pkg.sv
// Types shared by the link interrupt block
package lnk_pkg;
	typedef logic [7:0] lnk_byte_t; // One register byte
	typedef logic [11:0] lnk_addr_t; // Register port address
	typedef logic [111:0] lnk_cfg_t; // Fourteen-byte alignment configuration
endpackage

// ===== logic/lnk_regs.svh
// Register offsets, field positions, reset values and timing for the link interrupt block
`ifndef LNK_REGS_SVH
`define LNK_REGS_SVH

// Register offsets on the device register port
`define LNK_OFS_ENABLE_A 12'h4B8
`define LNK_OFS_ENABLE_B 12'h4B9
`define LNK_OFS_STATUS_A 12'h4BA
`define LNK_OFS_STATUS_B 12'h4BB

// Field positions shared by enable and status A
`define LNK_BIT_DISPARITY 7
`define LNK_BIT_NOT_IN_TABLE 6
`define LNK_BIT_UNEXP_CTRL 5
`define LNK_BIT_LANE_DESKEW 4
`define LNK_BIT_INIT_LANE_SYNC 3
`define LNK_BIT_CHECKSUM 2
`define LNK_BIT_FRAME_SYNC 1
`define LNK_BIT_CODE_GROUP_SYNC 0
// Only live bit of enable and status B
`define LNK_BIT_CONFIG_MISMATCH 0

// Reset values
`define LNK_RST_ENABLE_A 8'h00
`define LNK_RST_ENABLE_B 8'h00
`define LNK_RST_STATUS_A 8'h00
`define LNK_RST_STATUS_B 8'h00

// Alignment configuration image: fourteen bytes, checksum last
`define LNK_CFG_BYTES 14
// Comparison latency in clock cycles
`define LNK_CMP_CYCLES 1

`endif

// ===== test/lnk_irq_top_test.sv
// Self-checking bench for the link interrupt enable and status block
`timescale 1ns/10ps
`default_nettype none
`include "lnk_regs.svh"
// One compare, counted, reported at once on mismatch
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module lnk_irq_top_test
	import lnk_pkg::*;
;
	////////////////////////////////////////////////////////////////////////////
	logic clk = 1'b0; // 10 MHz bench clock
	logic resetn = 1'b0; // Held low for ten cycles
	logic ce = 1'b1; // Clock enable
	logic reg_wr = 1'b0; // Write strobe
	logic reg_rd = 1'b0; // Read strobe
	logic ilas_done = 1'b0; // Checksum pair valid
	logic lane0_ilas_done = 1'b0; // Lane 0 image valid
	logic [7:0] ev = 8'h00; // Event pulses by status A bit position
	lnk_addr_t reg_addr = 12'h000;
	lnk_byte_t reg_wdata = 8'h00, rx_checksum = 8'h00, calc_checksum = 8'h00, reg_rdata;
	lnk_cfg_t rx_cfg = {14{8'hA7}}, prog_cfg = {14{8'hA7}}; // Equal images at start
	logic link_irq;
	int n_mismatch = 0, num_checks = 0, cyc = 0;
	lnk_irq_top dut (.clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.disparity_err_evt(ev[7]), .not_in_table_evt(ev[6]), .unexp_ctrl_evt(ev[5]),
		.lane_deskew_evt(ev[4]), .init_lane_sync_evt(ev[3]), .frame_sync_evt(ev[1]),
		.code_group_sync_evt(ev[0]), .ilas_done(ilas_done), .rx_checksum(rx_checksum),
		.calc_checksum(calc_checksum), .lane0_ilas_done(lane0_ilas_done),
		.lane0_rx_cfg(rx_cfg), .prog_cfg(prog_cfg), .link_irq(link_irq));
	////////////////////////////////////////////////////////////////////////////
	// Free-running clock, 100 ns period
	initial forever #50 clk = ~clk;
	// Hang guard: whole run needs under two hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Single verdict point
	task automatic report_and_stop();
		if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// One-cycle write strobe, driven at the falling edge
	task automatic wr(input lnk_addr_t a, input lnk_byte_t d);
		@(negedge clk); reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
		@(negedge clk); reg_wr = 1'b0;
	endtask
	// Read data is registered, so it is looked at on the falling edge after the read edge
	task automatic rd(input lnk_addr_t a, input lnk_byte_t e);
		@(negedge clk); reg_addr = a; reg_rd = 1'b1;
		@(negedge clk); reg_rd = 1'b0;
		`CHK(reg_rdata, e)
	endtask
	// Event pulse; status lands at its edge, request one edge later
	task automatic pulse(input int i);
		@(negedge clk); ev[i] = 1'b1;
		@(negedge clk); ev = 8'h00;
		@(negedge clk);
	endtask
	// Checksum pair from the alignment sequence
	task automatic cks(input lnk_byte_t r, input lnk_byte_t c, input lnk_byte_t e);
		@(negedge clk); rx_checksum = r; calc_checksum = c; ilas_done = 1'b1;
		@(negedge clk); ilas_done = 1'b0; rx_checksum = ~r; calc_checksum = ~r;
		rd(`LNK_OFS_STATUS_A, e);
		wr(`LNK_OFS_STATUS_A, 8'hFF);
	endtask
	// Lane 0 image against programmed image; flag needs two edges
	task automatic cfg(input lnk_cfg_t r, input lnk_byte_t e);
		@(negedge clk); rx_cfg = r; lane0_ilas_done = 1'b1;
		@(negedge clk); lane0_ilas_done = 1'b0; rx_cfg = ~r;
		repeat (2) @(negedge clk);
		rd(`LNK_OFS_STATUS_B, e);
		`CHK(link_irq, e[0])
		wr(`LNK_OFS_STATUS_B, 8'h01);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		rd(`LNK_OFS_ENABLE_A, `LNK_RST_ENABLE_A);
		rd(`LNK_OFS_ENABLE_B, `LNK_RST_ENABLE_B);
		rd(`LNK_OFS_STATUS_A, `LNK_RST_STATUS_A);
		rd(`LNK_OFS_STATUS_B, `LNK_RST_STATUS_B);
		wr(`LNK_OFS_ENABLE_A, 8'hA5);
		rd(`LNK_OFS_ENABLE_A, 8'hA5);
		// Frozen clock enable must drop the write
		@(negedge clk); ce = 1'b0;
		wr(`LNK_OFS_ENABLE_A, 8'h5A);
		ce = 1'b1;
		rd(`LNK_OFS_ENABLE_A, 8'hA5);
		wr(`LNK_OFS_ENABLE_B, 8'hFF);
		rd(`LNK_OFS_ENABLE_B, 8'h01);
		wr(`LNK_OFS_STATUS_B, 8'hFE);
		rd(`LNK_OFS_STATUS_B, 8'h00);
		wr(12'h4BC, 8'hFF);
		rd(12'h4BC, 8'h00);
		// Each event source except checksum, masked: status set, no request
		wr(`LNK_OFS_ENABLE_A, 8'h00);
		for (int i = 0; i < 8; i++) begin
			if (i != `LNK_BIT_CHECKSUM) begin
				pulse(i);
				`CHK(link_irq, 1'b0)
				rd(`LNK_OFS_STATUS_A, 8'h01 << i);
				wr(`LNK_OFS_STATUS_A, 8'hFF);
			end
		end
		// Enabled source raises the request, clearing drops it
		wr(`LNK_OFS_ENABLE_A, 8'h02);
		pulse(`LNK_BIT_FRAME_SYNC);
		`CHK(link_irq, 1'b1)
		wr(`LNK_OFS_STATUS_A, 8'h00);
		rd(`LNK_OFS_STATUS_A, 8'h02);
		wr(`LNK_OFS_STATUS_A, 8'h02);
		@(negedge clk);
		`CHK(link_irq, 1'b0)
		// Event and write-one clear in one cycle: the event wins
		@(negedge clk);
		ev[`LNK_BIT_FRAME_SYNC] = 1'b1;
		reg_addr = `LNK_OFS_STATUS_A;
		reg_wdata = 8'h02;
		reg_wr = 1'b1;
		@(negedge clk);
		ev = 8'h00;
		reg_wr = 1'b0;
		rd(`LNK_OFS_STATUS_A, 8'h02);
		wr(`LNK_OFS_STATUS_A, 8'hFF);
		// Run without alignment sequence: software masks those results
		wr(`LNK_OFS_ENABLE_A, 8'hE1);
		pulse(`LNK_BIT_LANE_DESKEW);
		`CHK(link_irq, 1'b0)
		rd(`LNK_OFS_STATUS_A, 8'h10);
		wr(`LNK_OFS_STATUS_A, 8'hFF);
		// Programmed checksum byte differs, only link values count
		wr(`LNK_OFS_ENABLE_A, 8'h00);
		prog_cfg[111:104] = 8'h55;
		cks(8'h3C, 8'h3C, 8'h00);
		cks(8'h3C, 8'h3D, 8'h04);
		prog_cfg = {14{8'hA7}};
		// Configuration compare, checksum byte and first byte
		cfg({14{8'hA7}}, 8'h00);
		cfg({14{8'hA7}} ^ {8'h80, 104'h0}, 8'h01);
		cfg({14{8'hA7}} ^ 112'h1, 8'h01);
		wr(`LNK_OFS_ENABLE_B, 8'h00);
		rd(`LNK_OFS_ENABLE_B, 8'h00);
		report_and_stop();
	end
endmodule // lnk_irq_top_test
`default_nettype wire
